// *** dv/stl_line_model.sv ***
`timescale 1ns/100ps
// stands in for the framing and hdlc engines: slots rotate b1, b2, d, idle
// and data bits come from a shift pattern, so a stuck path shows quickly
module stl_line_model (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic q_load,
	output logic      sel_b1,
	output logic      sel_b2,
	output logic      sel_d,
	output logic      net_rx_b1,
	output logic      net_rx_b2,
	output logic      net_rx_d,
	output logic      bearer_one_tx_in,
	output logic      bearer_two_tx_in,
	output logic      hdlc_tx_d,
	output logic      mismatch_raw,
	output logic      frame_sync,
	output logic      mbit_sync,
	output logic      rx_frame_end,
	output logic      rx_fa_n_flipped,
	output logic      rx_bit15_end,
	output logic      q_word_sent
);
	logic [1:0] slot_q;
	logic [7:0] pat_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slot_q <= 2'h0;
			pat_q  <= 8'h5b;
		end else begin
			slot_q <= slot_q + 2'h1;
			pat_q  <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
		end
	end
	// a loaded q word goes out some cycles later, as the framing engine would send it
	logic [3:0] q_busy_q;
	always_ff @(posedge ref_clk) begin
		if (rst)
			q_busy_q <= 4'h0;
		else if (q_load)
			q_busy_q <= 4'hf;
		else if (q_busy_q != 4'h0)
			q_busy_q <= q_busy_q - 4'h1;
	end
	assign sel_b1 = slot_q == 2'h0;
	assign sel_b2 = slot_q == 2'h1;
	assign sel_d = slot_q == 2'h2;
	assign {rx_fa_n_flipped, mismatch_raw, hdlc_tx_d, bearer_two_tx_in} = pat_q[7:4];
	assign {bearer_one_tx_in, net_rx_d, net_rx_b2, net_rx_b1} = pat_q[3:0];
	assign frame_sync = 1'b1;
	assign mbit_sync = 1'b1;
	assign rx_frame_end = slot_q == 2'h3;
	assign rx_bit15_end = slot_q == 2'h1;
	assign q_word_sent = q_busy_q == 4'h1;
endmodule // stl_line_model

// *** dv/stl_regs_asserts.sv ***
`timescale 1ns/100ps
module stl_regs_asserts
	import stl_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        txq_underrun,
	input wire logic        last_frame_complete_tag,
	input wire logic        send_abort,
	input wire logic        clear_mismatch,
	input wire logic        mismatch_flag,
	input wire logic        hdlc_master_reset,
	input wire logic        st_master_reset,
	input wire logic        receiver_soft_reset,
	input wire logic        transmitter_soft_reset,
	input wire logic        force_bad_crc,
	input wire logic        timeout_pulse
);
	import stl_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic take;
	logic wr_sr;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_sr = take && wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == IDX_SOFT_RESET;
	ack_answer_a: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	mres_pulse_a: assert property (wr_sr && wb_dat_i[0] |-> ##[1:2] (hdlc_master_reset && st_master_reset))
		else $error("master reset not issued");
	receiver_soft_reset_pulse_a: assert property (wr_sr && wb_dat_i[1] |-> ##[1:2] receiver_soft_reset)
		else $error("receiver reset not issued");
	transmitter_soft_reset_pulse_a: assert property (wr_sr && wb_dat_i[2] |-> ##[1:2] transmitter_soft_reset)
		else $error("transmitter reset not issued");
	bad_crc_a: assert property (wr_sr |-> ##2 force_bad_crc == $past(wb_dat_i[4], 2))
		else $error("bad crc bit not applied");
	abort_send_a: assert property (txq_underrun && !last_frame_complete_tag |=> send_abort)
		else $error("underrun without abort");
	mismatch_hold_a: assert property (clear_mismatch && $past(clear_mismatch) |-> !mismatch_flag)
		else $error("mismatch flag not held low");
	timeout_single_a: assert property (timeout_pulse |=> !timeout_pulse)
		else $error("timeout pulse too long");
endmodule // stl_regs_asserts
bind stl_regs stl_regs_asserts chk_u (.*);

// *** dv/stl_regs_tb.sv ***
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_count++; \
	$display("FAIL %s expected %h seen %h", n, e, a); end end
module stl_regs_tb;
	import stl_pkg::*;
	logic        ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [5:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, priority_count, q_data;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [4:0]  txq_free;
	logic frame_sync, mbit_sync, rx_frame_end, rx_fa_n_flipped, rx_bit15_end, q_word_sent;
	logic clear_mismatch, mismatch_raw, net_rx_b1, net_rx_b2, net_rx_d, bearer_one_tx_in;
	logic bearer_two_tx_in, hdlc_tx_d, sel_b1, sel_b2, sel_d, txq_underrun, q_load;
	logic last_frame_complete_tag, net_tx_bit, rx_serial_out, mismatch_flag, send_abort;
	logic hdlc_master_reset, st_master_reset, receiver_soft_reset, transmitter_soft_reset;
	logic force_bad_crc, timeout_pulse;
	int err_count, n_checks, cyc_cnt, n_to, to_gap, to_last, n_hm;
	logic [7:0] rq;
	logic [7:0] lbv [4] = '{8'h07, 8'h90, 8'h41, 8'h12};
	// the timer tick is shortened so that interval counts fit a short run
	stl_regs #(.TICK_PERIOD(4)) dut_u (.*);
	stl_line_model line_u (.*);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (hdlc_master_reset === 1'b1) n_hm <= n_hm + 1;
		if (timeout_pulse === 1'b1) begin
			n_to <= n_to + 1;
			to_gap <= cyc_cnt - to_last;
			to_last <= cyc_cnt;
		end
		if (cyc_cnt == 3000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d,
			output logic [7:0] r);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		r = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		logic [7:0] r;
		wb(1'b1, idx, d, r);
	endtask
	task automatic rchk(input logic [3:0] idx, input logic [7:0] e, input string nm);
		logic [7:0] r;
		wb(1'b0, idx, 8'h00, r);
		`CHK(nm, e, r)
	endtask
	// outputs seen at an edge answer the inputs taken at the edge before
	task automatic path(input logic [7:0] lb);
		logic pb, pr, pt, pm, en, et;
		logic [2:0] k;
		pb = 1'b0;
		{pr, pt, pm} = 3'b000;
		k = 3'h0;
		repeat (16) begin
			@(posedge ref_clk);
			en = (k[2] | k[1]) ? 1'b1 : k[0] ? pr : pt;
			et = k[1] ? pt : pr;
			if (pb) `CHK("net_tx_bit", en, net_tx_bit)
			if (pb) `CHK("rx_serial_out", et, rx_serial_out)
			if (pb) `CHK("mismatch_flag", pm, mismatch_flag)
			pb = sel_b1 | sel_b2 | sel_d;
			k = sel_b1 ? {lb[7], lb[4], lb[1]} :
			    sel_b2 ? {lb[6], lb[3], lb[0]} : {1'b0, lb[5], lb[2]};
			pr = sel_b1 ? net_rx_b1 : sel_b2 ? net_rx_b2 : net_rx_d;
			pt = sel_b1 ? bearer_one_tx_in : sel_b2 ? bearer_two_tx_in : hdlc_tx_d;
			pm = mismatch_raw & ~clear_mismatch;
		end
	endtask
	initial begin
		{err_count, n_checks, cyc_cnt, n_to, to_gap, to_last, n_hm} = '0;
		{wb_cyc_i, wb_stb_i, wb_we_i, txq_underrun, last_frame_complete_tag} = '0;
		{wb_adr_i, wb_dat_i, txq_free, priority_count} = '0;
		wb_sel_i = 4'h1;
		clear_mismatch = 1'b0;
		rst = 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		rchk(IDX_LOOPBACK, LOOPBACK_RESET, "loopback reset");
		rchk(IDX_TIMER, TIMER_RESET, "timer reset");
		rchk(4'h0, 8'h00, "unmapped read");
		path(LOOPBACK_RESET);
		foreach (lbv[i]) begin
			wr(IDX_LOOPBACK, lbv[i]);
			path(lbv[i]);
		end
		$display("loopback test done");
		wr(IDX_TIMER, 8'ha0);
		n_to = 0;
		wr(IDX_TIMER, 8'he0);
		repeat (20) @(posedge ref_clk);
		`CHK("immediate pulses", 1, n_to)
		n_to = 0;
		wr(IDX_TIMER, 8'h61);
		repeat (40) @(posedge ref_clk);
		`CHK("one-shot pulses", 1, n_to)
		wr(IDX_TIMER, 8'h21);
		repeat (30) @(posedge ref_clk);
		`CHK("timer period", 8, to_gap)
		wr(IDX_TIMER, 8'h35);
		rchk(IDX_TIMER, 8'h25, "invalid mode");
		wr(IDX_TIMER, 8'ha0);
		$display("timer test done");
		txq_free <= 5'h13;
		rchk(IDX_TXQ_STATUS, 8'h13, "queue free");
		txq_underrun <= 1'b1;
		@(posedge ref_clk);
		txq_underrun <= 1'b0;
		rchk(IDX_TXQ_STATUS, 8'h33, "underrun set");
		rchk(IDX_TXQ_STATUS, 8'h13, "underrun clear");
		$display("queue test done");
		wr(IDX_Q_STATUS, 8'h1a);
		`CHK("q data out", 4'ha, q_data)
		wb(1'b0, IDX_Q_STATUS, 8'h00, rq);
		`CHK("q loading", 6'h1a, rq[5:0])
		wr(IDX_Q_STATUS, 8'h15);
		`CHK("q write refused", 4'ha, q_data)
		repeat (20) @(posedge ref_clk);
		wb(1'b0, IDX_Q_STATUS, 8'h00, rq);
		`CHK("q done", 6'h2a, rq[5:0])
		wr(IDX_Q_STATUS, 8'h15);
		`CHK("q data reload", 4'h5, q_data)
		wb(1'b0, IDX_Q_STATUS, 8'h00, rq);
		`CHK("q reload", 6'h15, rq[5:0])
		$display("q test done");
		priority_count <= 4'h9;
		rchk(IDX_SOFT_RESET, 8'h09, "priority count");
		wr(IDX_SOFT_RESET, 8'h07);
		rchk(IDX_LOOPBACK, 8'h12, "loopback kept");
		`CHK("master resets", 1, n_hm)
		wr(IDX_SOFT_RESET, 8'h10);
		rchk(IDX_SOFT_RESET, 8'h19, "bad crc read");
		`CHK("bad crc out", 1'b1, force_bad_crc)
		wr(IDX_SOFT_RESET, 8'h00);
		clear_mismatch <= 1'b1;
		wr(IDX_LOOPBACK, 8'h20);
		repeat (8) @(posedge ref_clk);
		`CHK("mismatch held", 1'b0, mismatch_flag)
		path(8'h20);
		$display("reset test done");
		end_sim();
	end
endmodule // stl_regs_tb

// *** hw/stl_pkg.sv ***
package stl_pkg;
	localparam int unsigned ADDR_W = 4;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_Q_STATUS   = 4'hb;
	localparam logic [3:0] IDX_LOOPBACK   = 4'hc;
	localparam logic [3:0] IDX_TIMER      = 4'hd;
	localparam logic [3:0] IDX_TXQ_STATUS = 4'he;
	localparam logic [3:0] IDX_SOFT_RESET = 4'hf;

	// q register fields
	localparam int unsigned Q_ENFLG_BIT = 4;
	localparam int unsigned Q_DONE_BIT  = 5;
	localparam int unsigned Q_SYNC_BIT  = 7;

	// loopback bits
	localparam int unsigned LB_REMOTE_LOOP_BEARER_TWO = 0;
	localparam int unsigned LB_REMOTE_LOOP_BEARER_ONE = 1;
	localparam int unsigned LB_RLD  = 2;
	localparam int unsigned LB_LOCAL_LOOP_BEARER_TWO = 3;
	localparam int unsigned LB_LOCAL_LOOP_BEARER_ONE = 4;
	localparam int unsigned LB_LLD  = 5;
	localparam int unsigned LB_FORCE_ONES_BEARER_TWO = 6;
	localparam int unsigned LB_FORCE_ONES_BEARER_ONE = 7;
	localparam logic [7:0] LOOPBACK_RESET = 8'h48;

	// timer
	localparam logic [3:0] TMODE_PERIODIC  = 4'h2;
	localparam logic [3:0] TMODE_ONESHOT   = 4'h6;
	localparam logic [3:0] TMODE_DISABLED  = 4'ha;
	localparam logic [3:0] TMODE_IMMEDIATE = 4'he;
	localparam logic [7:0] TIMER_RESET     = 8'h2f;
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned TICK_MS        = 127;
	localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;

	// reset/priority register
	localparam int unsigned SR_MRES  = 0;
	localparam int unsigned SR_RECEIVER_SOFT_RESET  = 1;
	localparam int unsigned SR_TRANSMITTER_SOFT_RESET  = 2;
	localparam int unsigned SR_FORCE_BAD_CRC = 4;

	localparam int unsigned TXQ_UNDERRUN_ABORT_FLAG_BIT = 5;
endpackage

// *** hw/stl_regs.sv ***
`timescale 1ns/100ps
// Functional notes
// - q-done sets after a 4-bit q word is sent, holds until new q word loaded
// - q sync needs frame sync, m sync, and fa=1 n=0 five frames after previous
// - q sync rises at end of receive bit 15, falls at once on sync loss
// - remote loop b2/b1 returns received bearer data to the network
// - remote d loop returns received d data to the network
// - local b2 loop routes transmit input to receive output, ones to network
// - local b1 loop routes transmit input to receive output, ones to network
// - local d loop returns hdlc data and sends ones; software sets clear-mismatch
// - force-ones bits replace that bearer's outgoing traffic with ones
// - reset leaves remote and d loops off, local b2 loop and b2 ones on
// - interval bits give timeout as (code+1) times 0.127 s
// - mode codes periodic, one-shot, disabled, immediate; others ignored
// - writing a valid mode code restarts the timer
// - low five bits give free bytes of the hdlc transmit queue
// - underrun without frame-complete tag aborts and sets bit 5, cleared by read
// - master reset resets hdlc and s/t controllers, not timer nor registers
// - registers reset only by power-up or reset pin
// - receiver reset clears receive queue, end-of-frame and fill flags
// - transmitter reset reinitialises queue status, clears done and empty flags
// - reset register writes are resets and the bad-crc bit; reads return that bit and the priority counter
// - bad-crc bit forces corrupted crc; default zero
// - q nibble written with flag high; device clears flag when writable
// - clear-mismatch bit holds the mismatch flag at zero
module stl_regs
	import stl_pkg::*;
#(
	parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// classic wishbone slave
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	input  wire logic       wb_we_i,
	input  wire logic [5:0] wb_adr_i,
	input  wire logic [3:0] wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]     wb_dat_o,
	output logic            wb_ack_o,
	// framing engine
	input  wire logic       frame_sync,
	input  wire logic       mbit_sync,
	input  wire logic       rx_frame_end,
	input  wire logic       rx_fa_n_flipped,
	input  wire logic       rx_bit15_end,
	input  wire logic       q_word_sent,
	input  wire logic       clear_mismatch,
	input  wire logic       mismatch_raw,
	// bearer and d channel bit streams, one bit per channel slot
	input  wire logic       net_rx_b1,
	input  wire logic       net_rx_b2,
	input  wire logic       net_rx_d,
	input  wire logic       bearer_one_tx_in,
	input  wire logic       bearer_two_tx_in,
	input  wire logic       hdlc_tx_d,
	input  wire logic       sel_b1,
	input  wire logic       sel_b2,
	input  wire logic       sel_d,
	// hdlc engine status
	input  wire logic [4:0] txq_free,
	input  wire logic       txq_underrun,
	input  wire logic       last_frame_complete_tag,
	input  wire logic [3:0] priority_count,
	output logic            net_tx_bit,
	output logic            rx_serial_out,
	output logic            mismatch_flag,
	output logic [3:0]      q_data,
	output logic            q_load,
	output logic            hdlc_master_reset,
	output logic            st_master_reset,
	output logic            receiver_soft_reset,
	output logic            transmitter_soft_reset,
	output logic            send_abort,
	output logic            force_bad_crc,
	output logic            timeout_pulse
);
	////////////////////////////////////////////////////////////////////////
	// bus decode

	logic [7:0] q_reg_q;
	logic       q_done_q;
	logic       q_sync_q;
	logic [7:0] loop_q;
	logic [7:0] timer_q;
	logic       underrun_abort_flag_q;
	logic [7:0] sr_q;

	wire        wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        wb_wr      = wb_req && wb_we_i && wb_sel_i[0];
	wire        wb_rd      = wb_req && !wb_we_i;
	wire [3:0]  wb_idx     = wb_adr_i[5:2];
	wire [7:0]  wd         = wb_dat_i[7:0];
	wire        wr_q       = wb_wr && (wb_idx == IDX_Q_STATUS);
	wire        wr_loop    = wb_wr && (wb_idx == IDX_LOOPBACK);
	wire        wr_timer   = wb_wr && (wb_idx == IDX_TIMER);
	wire        wr_sr      = wb_wr && (wb_idx == IDX_SOFT_RESET);
	// a q write is refused while the previous word still waits to go out
	wire        q_accept   = wr_q && !q_reg_q[Q_ENFLG_BIT];
	wire        rd_txq     = wb_rd && (wb_idx == IDX_TXQ_STATUS);
	wire [3:0]  new_mode   = wd[7:4];
	wire        mode_valid = (new_mode == TMODE_PERIODIC) || (new_mode == TMODE_ONESHOT) ||
	                         (new_mode == TMODE_DISABLED) || (new_mode == TMODE_IMMEDIATE);

	wire [7:0]  rd_q    = {q_sync_q, 1'b0, q_done_q, q_reg_q[4:0]};
	wire [7:0]  rd_txq_v = {2'b00, underrun_abort_flag_q, txq_free};
	wire [7:0]  rd_sr   = {3'b000, sr_q[SR_FORCE_BAD_CRC], priority_count};
	logic [7:0] rd_mux;
	always_comb begin
		case (wb_idx)
			IDX_Q_STATUS:   rd_mux = rd_q;
			IDX_LOOPBACK:   rd_mux = loop_q;
			IDX_TIMER:      rd_mux = timer_q;
			IDX_TXQ_STATUS: rd_mux = rd_txq_v;
			IDX_SOFT_RESET: rd_mux = rd_sr;
			default:        rd_mux = 8'h00;
		endcase
	end

	// one wait-free cycle: ack one edge after the request, unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= {24'h0, rd_mux};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// q channel

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q_reg_q  <= 8'h00;
			q_done_q <= 1'b0;
			q_load   <= 1'b0;
			q_data   <= 4'h0;
		end else begin
			q_load <= q_accept && wd[Q_ENFLG_BIT];
			if (q_accept) begin
				q_reg_q <= {3'b000, wd[4:0]}; // bit 6 not stored
				q_data  <= wd[3:0];
			end else if (q_word_sent) begin
				q_reg_q[Q_ENFLG_BIT] <= 1'b0;
			end
			// sent wins over a same-cycle load
			if (q_word_sent)
				q_done_q <= 1'b1;
			else if (q_accept && wd[Q_ENFLG_BIT])
				q_done_q <= 1'b0;
		end
	end

	// fa/n flip must recur exactly five frames apart
	logic [2:0] frame_cnt_q;
	logic       five_ok_q;
	wire        synced = frame_sync && mbit_sync;
	always_ff @(posedge ref_clk) begin
		if (rst || !synced) begin
			frame_cnt_q <= 3'h0;
			five_ok_q   <= 1'b0;
			q_sync_q    <= 1'b0;
		end else begin
			if (rx_frame_end) begin
				if (rx_fa_n_flipped) begin
					five_ok_q   <= (frame_cnt_q == 3'h4);
					frame_cnt_q <= 3'h0;
				end else if (frame_cnt_q == 3'h5) begin
					five_ok_q <= 1'b0;
				end else begin
					frame_cnt_q <= frame_cnt_q + 3'h1;
				end
			end
			if (rx_bit15_end)
				q_sync_q <= five_ok_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// loopback and data path

	always_ff @(posedge ref_clk) begin
		if (rst)
			loop_q <= LOOPBACK_RESET;
		else if (wr_loop)
			loop_q <= wd;
	end

	// forced ones win over a remote loop, so a silenced channel stays silent
	wire b1_net = (loop_q[LB_FORCE_ONES_BEARER_ONE] || loop_q[LB_LOCAL_LOOP_BEARER_ONE]) ? 1'b1 :
	              loop_q[LB_REMOTE_LOOP_BEARER_ONE] ? net_rx_b1 : bearer_one_tx_in;
	wire b2_net = (loop_q[LB_FORCE_ONES_BEARER_TWO] || loop_q[LB_LOCAL_LOOP_BEARER_TWO]) ? 1'b1 :
	              loop_q[LB_REMOTE_LOOP_BEARER_TWO] ? net_rx_b2 : bearer_two_tx_in;
	wire d_net  = loop_q[LB_LLD] ? 1'b1 :
	              loop_q[LB_RLD] ? net_rx_d : hdlc_tx_d;
	wire b1_term = loop_q[LB_LOCAL_LOOP_BEARER_ONE] ? bearer_one_tx_in : net_rx_b1;
	wire b2_term = loop_q[LB_LOCAL_LOOP_BEARER_TWO] ? bearer_two_tx_in : net_rx_b2;
	wire d_term  = loop_q[LB_LLD] ? hdlc_tx_d : net_rx_d;
	wire net_bit = sel_b1 ? b1_net : sel_b2 ? b2_net : sel_d ? d_net : 1'b1;
	wire trm_bit = sel_b1 ? b1_term : sel_b2 ? b2_term : sel_d ? d_term : 1'b1;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			net_tx_bit    <= 1'b1;
			rx_serial_out <= 1'b1;
			mismatch_flag <= 1'b0;
		end else begin
			net_tx_bit    <= net_bit;
			rx_serial_out <= trm_bit;
			mismatch_flag <= mismatch_raw && !clear_mismatch;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timer

	typedef enum logic [1:0] {STL_T_IDLE, STL_T_RUN} stl_tstate_e;
	stl_tstate_e t_state_q;
	logic [3:0]  t_left_q;
	logic        tick;
	wire         t_restart = wr_timer && mode_valid;
	wire [3:0]   t_mode    = timer_q[7:4];

	stl_tick_div #(
		.PERIOD (TICK_PERIOD)
	) u_tick (
		.ref_clk (ref_clk),
		.rst     (rst),
		.restart (t_restart),
		.tick    (tick)
	);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			timer_q <= TIMER_RESET;
		end else if (wr_timer) begin
			timer_q[3:0] <= wd[3:0];
			if (mode_valid)
				timer_q[7:4] <= new_mode;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			t_state_q     <= STL_T_RUN;
			t_left_q      <= TIMER_RESET[3:0];
			timeout_pulse <= 1'b0;
		end else begin
			timeout_pulse <= 1'b0;
			if (t_restart) begin
				t_left_q <= wd[3:0];
				if (new_mode == TMODE_IMMEDIATE) begin
					timeout_pulse <= 1'b1;
					t_state_q     <= STL_T_IDLE;
				end else if (new_mode == TMODE_DISABLED) begin
					t_state_q <= STL_T_IDLE;
				end else begin
					t_state_q <= STL_T_RUN;
				end
			end else begin
				case (t_state_q)
					STL_T_IDLE: t_state_q <= STL_T_IDLE;
					STL_T_RUN: begin
						if (tick) begin
							if (t_left_q == 4'h0) begin
								timeout_pulse <= 1'b1;
								t_left_q      <= timer_q[3:0];
								if (t_mode == TMODE_ONESHOT)
									t_state_q <= STL_T_IDLE;
							end else begin
								t_left_q <= t_left_q - 4'h1;
							end
						end
					end
					default: t_state_q <= STL_T_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit queue status and soft resets

	// underrun set wins over the clearing read
	wire underrun_abort = txq_underrun && !last_frame_complete_tag;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			underrun_abort_flag_q   <= 1'b0;
			send_abort <= 1'b0;
		end else begin
			send_abort <= underrun_abort;
			if (underrun_abort)
				underrun_abort_flag_q <= 1'b1;
			else if (rd_txq)
				underrun_abort_flag_q <= 1'b0;
		end
	end

	// reset bits self-clear: each write of a one gives a one-cycle reset pulse
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sr_q                   <= 8'h00;
			hdlc_master_reset      <= 1'b0;
			st_master_reset        <= 1'b0;
			receiver_soft_reset    <= 1'b0;
			transmitter_soft_reset <= 1'b0;
			force_bad_crc          <= 1'b0;
		end else begin
			if (wr_sr)
				sr_q <= {3'b000, wd[SR_FORCE_BAD_CRC], 4'h0};
			hdlc_master_reset      <= wr_sr && wd[SR_MRES];
			st_master_reset        <= wr_sr && wd[SR_MRES];
			receiver_soft_reset    <= wr_sr && (wd[SR_RECEIVER_SOFT_RESET] || wd[SR_MRES]);
			transmitter_soft_reset <= wr_sr && (wd[SR_TRANSMITTER_SOFT_RESET] || wd[SR_MRES]);
			force_bad_crc          <= wr_sr ? wd[SR_FORCE_BAD_CRC] : sr_q[SR_FORCE_BAD_CRC];
		end
	end
endmodule // stl_regs

// *** hw/stl_tick_div.sv ***
`timescale 1ns/100ps
// one-cycle enable every period cycles; restart realigns the phase
module stl_tick_div #(
	parameter int unsigned PERIOD = 10
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic restart,
	output logic      tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge ref_clk) begin
		if (rst || restart) begin
			cnt_q <= 32'h0;
			tick  <= 1'b0;
		end else if (cnt_q == PERIOD - 1) begin
			cnt_q <= 32'h0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick  <= 1'b0;
		end
	end
endmodule // stl_tick_div
